// [hw/fir_cfg_pkg.sv]
`default_nettype none

package fir_cfg_pkg;

    // Configuration register indices loaded into the index register
    localparam logic [7:0] IDX_BASE_ADDR  = 8'h2b;
    localparam logic [7:0] IDX_DMA_SEL    = 8'h2c;
    localparam logic [7:0] IDX_TIMEOUT    = 8'h2d;
    localparam logic [7:0] IDX_SSEL_FIRST = 8'h2e;
    localparam logic [7:0] IDX_SSEL_SECOND = 8'h2f;

    // Power-up values
    localparam logic [7:0] RST_BASE_ADDR  = 8'h00;
    localparam logic [7:0] RST_DMA_SEL    = 8'h00;
    localparam logic [7:0] RST_TIMEOUT    = 8'h03;
    localparam logic [7:0] RST_SSEL       = 8'h00;
    localparam logic [7:0] RST_INDEX      = 8'h00;

    // Base address field: register bits 7..0 carry I/O address bits 10..3
    localparam int unsigned BASE_ADDR_LSB = 3;
    localparam int unsigned BASE_ADDR_MSB = 10;
    localparam int unsigned BASE_EN_LSB   = 5;

    // DMA select field
    localparam int unsigned DMA_FIELD_W   = 4;
    localparam logic [3:0]  DMA_NONE      = 4'h0;
    localparam logic [3:0]  DMA_CH_A      = 4'h1;
    localparam logic [3:0]  DMA_CH_B      = 4'h2;
    localparam logic [3:0]  DMA_CH_C      = 4'h3;
    localparam int unsigned DMA_CHANNELS  = 3;

    // Engine-side locations of the mirrored registers
    localparam logic [2:0] ENG_BLK_SSEL    = 3'h3;
    localparam logic [2:0] ENG_OFS_SSEL_A  = 3'h5;
    localparam logic [2:0] ENG_OFS_SSEL_B  = 3'h6;
    localparam logic [2:0] ENG_BLK_TIMEOUT = 3'h5;
    localparam logic [2:0] ENG_OFS_TIMEOUT = 3'h1;

    // Turnaround time step and clock
    localparam int unsigned CLK_HZ          = 25_000_000;
    localparam int unsigned TIMEOUT_STEP_NS = 100_000;
    localparam int unsigned TIMEOUT_STEP_CYC = (TIMEOUT_STEP_NS / 1000) * (CLK_HZ / 1_000_000);
    localparam int unsigned TIMEOUT_CYC_W   = 20;

endpackage : fir_cfg_pkg

`default_nettype wire

// [hw/fir_mirror_reg.sv]
`default_nettype none

// One byte of storage reachable from two write paths
module fir_mirror_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       cfg_we,
    input  wire logic [7:0] cfg_wdata,
    input  wire logic       eng_we,
    input  wire logic [7:0] eng_wdata,
    output var  logic [7:0] value_q
);

    // Single register so both paths always agree; host config write wins a tie
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            value_q <= RESET_VALUE;
        end else if (cfg_we) begin
            value_q <= cfg_wdata;
        end else if (eng_we) begin
            value_q <= eng_wdata;
        end
    end

endmodule : fir_mirror_reg

`default_nettype wire

// [hw/fir_cfg_regs.sv]
// Operation
// - The base-address register is reached only in configuration state with its index loaded, and powers up to zero.
// - The base-address register supplies engine I/O address bits 10 to 3 on eight-byte boundaries.
// - Engine decoding is off whenever base bits 10, 9 and 8 are all zero.
// - Engine registers answer only with chip select low, and host address bits 2 to 0 are ignored in the match.
// - The DMA-select register is reached only in configuration state with its index loaded, and powers up to zero.
// - DMA-select bits 3 to 0 pick none, channel A, B or C for the engine.
// - DMA-select bits 7 to 4 ignore writes and read as zero.
// - Every DMA request output that is not selected is left undriven.
// - The turnaround time-out register is reached only in configuration state with its index loaded, and powers up to three.
// - The turnaround time-out equals the register value times 100 microseconds.
// - The configuration time-out and the engine block 5 offset 1 time-out stay equal, updated by either write or by power-on reset.
// - An engine software reset leaves both time-out copies unchanged.
// - The first software-select register is reached only in configuration state with its index loaded, and powers up to zero.
// - The first software-select register is the same storage as engine block 3 offset 5.
// - The second software-select register is reached only in configuration state with its index loaded, and powers up to zero.
// - The second software-select register is the same storage as engine block 3 offset 6.
`default_nettype none

// Configuration bank of the fast infrared engine.
// Index/data host access, engine window decode,
// DMA request steering and bytes shared with the engine.
// One clock throughout; only chip select is a pin.
// Read outputs idle at zero when not answering.
module fir_cfg_regs #(
    parameter int unsigned HOST_ADDR_W = 16
) (
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Configuration access port
    input  wire logic                   cfg_state,
    input  wire logic                   idx_wr,
    input  wire logic                   dat_wr,
    input  wire logic                   dat_rd,
    input  wire logic [7:0]             cfg_wdata,
    output var  logic [7:0]             cfg_rdata_q,
    output var  logic                   cfg_rdata_oe_q,
    output var  logic [7:0]             config_index_register_q,
    // Host I/O decode for the engine window
    input  wire logic [HOST_ADDR_W-1:0] host_addr,
    input  wire logic                   chip_select_low,
    output var  logic                   eng_select_q,
    output var  logic [2:0]             eng_reg_offset_q,
    // Engine register path to the shared bytes
    input  wire logic                   eng_wr,
    input  wire logic                   eng_rd,
    input  wire logic [2:0]             eng_block,
    input  wire logic [2:0]             eng_offset,
    input  wire logic [7:0]             eng_wdata,
    input  wire logic                   eng_soft_rst,
    output var  logic [7:0]             eng_rdata_q,
    output var  logic                   eng_rdata_valid_q,
    // DMA request steering
    input  wire logic                   eng_dma_req,
    output var  logic [2:0]             drq_out_q,
    output var  logic [2:0]             drq_oe_q,
    // Settings seen by the engine
    output var  logic [7:0]             turnaround_timeout_q,
    output var  logic [19:0]            turnaround_cycles_q,
    output var  logic [7:0]             ssel_first_q,
    output var  logic [7:0]             ssel_second_q
);

    // Registers held here
    // Index, base and DMA select live here only
    logic [7:0] index_q;
    logic [7:0] base_addr_q;
    logic [3:0] dma_sel_q;
    // Slot 0 time-out, 1 first select, 2 second select
    logic [7:0] mirror_q [3];
    logic       cs_meta_q;
    logic       cs_sync_q;

    // Write strobes decoded from index and state
    // Host strobes qualified by configuration state
    logic       cfg_we_base;
    logic       cfg_we_dma;
    logic [2:0] cfg_we_mirror;
    logic [2:0] eng_we_mirror;
    logic [7:0] cfg_rdata_d;
    logic [7:0] eng_rdata_d;
    logic       decode_en;
    logic       addr_match;
    logic       cfg_wr_ok;
    logic       cfg_rd_ok;

    // Index match used by the write path; the read mux uses its own case
    function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] want);
        idx_is = (idx == want);
    endfunction : idx_is

    // Engine location match used by both write and read path
    function automatic logic eng_at(input logic [2:0] blk, input logic [2:0] ofs,
                                    input logic [2:0] want_blk, input logic [2:0] want_ofs);
        eng_at = (blk == want_blk) && (ofs == want_ofs);
    endfunction : eng_at

    // Channel match for the request pins; pin c answers to code c + 1
    function automatic logic dma_hit(input logic [3:0] sel, input int unsigned chan);
        dma_hit = (sel == 4'(chan + 1));
    endfunction : dma_hit

    // Index register loads only in configuration state,
    // so a write outside it cannot redirect later access
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            index_q <= fir_cfg_pkg::RST_INDEX;
        end else if (cfg_state && idx_wr) begin
            index_q <= cfg_wdata;
        end
    end

    // Host data strobes need configuration state
    always_comb begin
        cfg_wr_ok = cfg_state && dat_wr;
        cfg_rd_ok = cfg_state && dat_rd;
    end

    // Data writes also need a matching index;
    // an index naming none of these writes nowhere
    always_comb begin
        cfg_we_base      = cfg_wr_ok && idx_is(index_q, fir_cfg_pkg::IDX_BASE_ADDR);
        cfg_we_dma       = cfg_wr_ok && idx_is(index_q, fir_cfg_pkg::IDX_DMA_SEL);
        cfg_we_mirror[0] = cfg_wr_ok && idx_is(index_q, fir_cfg_pkg::IDX_TIMEOUT);
        cfg_we_mirror[1] = cfg_wr_ok && idx_is(index_q, fir_cfg_pkg::IDX_SSEL_FIRST);
        cfg_we_mirror[2] = cfg_wr_ok && idx_is(index_q, fir_cfg_pkg::IDX_SSEL_SECOND);
    end

    // Engine path writes into the same storage
    // No state gating: the engine owns its window
    always_comb begin
        eng_we_mirror[0] = eng_wr && eng_at(eng_block, eng_offset,
                                            fir_cfg_pkg::ENG_BLK_TIMEOUT,
                                            fir_cfg_pkg::ENG_OFS_TIMEOUT);
        eng_we_mirror[1] = eng_wr && eng_at(eng_block, eng_offset,
                                            fir_cfg_pkg::ENG_BLK_SSEL,
                                            fir_cfg_pkg::ENG_OFS_SSEL_A);
        eng_we_mirror[2] = eng_wr && eng_at(eng_block, eng_offset,
                                            fir_cfg_pkg::ENG_BLK_SSEL,
                                            fir_cfg_pkg::ENG_OFS_SSEL_B);
    end

    // Base address register: I/O address bits 10..3;
    // its top three bits double as the decode enable
    // so a cleared base cannot alias a low address
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            base_addr_q <= fir_cfg_pkg::RST_BASE_ADDR;
        end else if (cfg_we_base) begin
            base_addr_q <= cfg_wdata;
        end
    end

    // DMA select keeps only the low nibble; upper bits have no storage
    // Reserved bits thus read back as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dma_sel_q <= fir_cfg_pkg::RST_DMA_SEL[3:0];
        end else if (cfg_we_dma) begin
            dma_sel_q <= cfg_wdata[3:0];
        end
    end

    // Shared bytes: time-out, first and second software select.
    // One flop per byte serves both paths,
    // so the two views can never drift apart.
    // Only the device reset reloads them; the engine soft reset is not wired in.
    localparam logic [7:0] MIRROR_RST [3] = '{fir_cfg_pkg::RST_TIMEOUT,
                                              fir_cfg_pkg::RST_SSEL,
                                              fir_cfg_pkg::RST_SSEL};
    for (genvar i = 0; i < 3; i++) begin : g_mirror
        fir_mirror_reg #(
            .RESET_VALUE (MIRROR_RST[i])
        ) u_mirror (
            .clk       (clk),
            .rst       (rst),
            .cfg_we    (cfg_we_mirror[i]),
            .cfg_wdata (cfg_wdata),
            .eng_we    (eng_we_mirror[i]),
            .eng_wdata (eng_wdata),
            .value_q   (mirror_q[i])
        );
    end

    // Configuration read mux; unmapped indices read zero.
    // Reads have no side effect on any register,
    // so the mux can run every cycle
    always_comb begin
        cfg_rdata_d = 8'h00;
        case (index_q)
            fir_cfg_pkg::IDX_BASE_ADDR: begin
                cfg_rdata_d = base_addr_q;
            end
            fir_cfg_pkg::IDX_DMA_SEL: begin
                cfg_rdata_d = {4'h0, dma_sel_q};
            end
            fir_cfg_pkg::IDX_TIMEOUT: begin
                cfg_rdata_d = mirror_q[0];
            end
            fir_cfg_pkg::IDX_SSEL_FIRST: begin
                cfg_rdata_d = mirror_q[1];
            end
            fir_cfg_pkg::IDX_SSEL_SECOND: begin
                cfg_rdata_d = mirror_q[2];
            end
            default: begin
                cfg_rdata_d = 8'h00;
            end
        endcase
    end

    // Read data is driven for one cycle, only in configuration state;
    // at other times it is held at zero so a shared
    // read bus sees nothing from this bank
    // while another block answers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_rdata_q    <= 8'h00;
            cfg_rdata_oe_q <= 1'b0;
        end else begin
            cfg_rdata_oe_q <= cfg_rd_ok;
            cfg_rdata_q    <= cfg_rd_ok ? cfg_rdata_d : 8'h00;
        end
    end

    // Index register visible to the rest of the configuration logic
    // It lags the index by one clock
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            config_index_register_q <= fir_cfg_pkg::RST_INDEX;
        end else begin
            config_index_register_q <= index_q;
        end
    end

    // Engine read of the shared bytes; other locations read zero here
    // Engine copies of other locations live elsewhere
    always_comb begin
        eng_rdata_d = 8'h00;
        if (eng_at(eng_block, eng_offset, fir_cfg_pkg::ENG_BLK_TIMEOUT,
                   fir_cfg_pkg::ENG_OFS_TIMEOUT)) begin
            eng_rdata_d = mirror_q[0];
        end else if (eng_at(eng_block, eng_offset, fir_cfg_pkg::ENG_BLK_SSEL,
                            fir_cfg_pkg::ENG_OFS_SSEL_A)) begin
            eng_rdata_d = mirror_q[1];
        end else if (eng_at(eng_block, eng_offset, fir_cfg_pkg::ENG_BLK_SSEL,
                            fir_cfg_pkg::ENG_OFS_SSEL_B)) begin
            eng_rdata_d = mirror_q[2];
        end
    end

    // Engine read answer one clock after the strobe;
    // data idles at zero so it can be merged
    // by a plain OR outside this bank
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eng_rdata_q       <= 8'h00;
            eng_rdata_valid_q <= 1'b0;
        end else begin
            eng_rdata_valid_q <= eng_rd;
            eng_rdata_q       <= eng_rd ? eng_rdata_d : 8'h00;
        end
    end

    // Chip select is a pin: two flops before the decode looks at it.
    // Both reset to the deselected level,
    // so no false select follows reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
        end else begin
            cs_meta_q <= chip_select_low;
            cs_sync_q <= cs_meta_q;
        end
    end

    // Window compare on address bits 10..3; bits 2..0 pick the register
    // Address bits above 10 are ignored,
    // as the base covers only bits 10..3
    always_comb begin
        decode_en  = |base_addr_q[7:fir_cfg_pkg::BASE_EN_LSB];
        addr_match = (host_addr[fir_cfg_pkg::BASE_ADDR_MSB:fir_cfg_pkg::BASE_ADDR_LSB]
                      == base_addr_q);
    end

    // Registered select; the host holds address steady for the access
    // so the select trails chip select by three clocks
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            eng_select_q     <= 1'b0;
            eng_reg_offset_q <= 3'h0;
        end else begin
            eng_select_q     <= decode_en && addr_match && !cs_sync_q;
            eng_reg_offset_q <= host_addr[2:0];
        end
    end

    // One request pin per channel; only the selected one is enabled.
    // Pins of unselected channels keep their enable low,
    // which the pad turns into a released line;
    // codes above three select no pin at all
    for (genvar c = 0; c < fir_cfg_pkg::DMA_CHANNELS; c++) begin : g_drq
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                drq_oe_q[c]  <= 1'b0;
                drq_out_q[c] <= 1'b0;
            end else begin
                drq_oe_q[c]  <= dma_hit(dma_sel_q, c);
                drq_out_q[c] <= dma_hit(dma_sel_q, c) && eng_dma_req;
            end
        end
    end

    // Settings handed to the engine, with the turnaround length in clock cycles
    // Byte and cycle count register together, so they agree;
    // 255 steps give 637500 cycles, inside 20 bits.
    // A faster clock would need a wider count.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            turnaround_timeout_q <= fir_cfg_pkg::RST_TIMEOUT;
            turnaround_cycles_q  <= 20'(32'(fir_cfg_pkg::RST_TIMEOUT)
                                        * fir_cfg_pkg::TIMEOUT_STEP_CYC);
            ssel_first_q         <= fir_cfg_pkg::RST_SSEL;
            ssel_second_q        <= fir_cfg_pkg::RST_SSEL;
        end else begin
            turnaround_timeout_q <= mirror_q[0];
            turnaround_cycles_q  <= 20'(32'(mirror_q[0])
                                        * fir_cfg_pkg::TIMEOUT_STEP_CYC);
            ssel_first_q         <= mirror_q[1];
            ssel_second_q        <= mirror_q[2];
        end
    end

    // Soft reset of the engine is accepted and deliberately unused here
    // Kept as a port so the engine wires up without a dangling pin
    logic soft_rst_seen;
    assign soft_rst_seen = eng_soft_rst;

endmodule : fir_cfg_regs

`default_nettype wire

// [hw/fir_dummy_unused.sv]
`default_nettype none
`default_nettype wire

// [verification/fir_cfg_regs_assertions.sv]
`default_nettype none

// Port-level checks; read data, request pins, cycle count and mirror relations, no internal state seen
module fir_cfg_regs_chk (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        cfg_state,
    input wire logic        dat_rd,
    input wire logic        eng_rd,
    input wire logic [2:0]  eng_block,
    input wire logic [2:0]  eng_offset,
    input wire logic [7:0]  cfg_rdata_q,
    input wire logic        cfg_rdata_oe_q,
    input wire logic [7:0]  eng_rdata_q,
    input wire logic        eng_rdata_valid_q,
    input wire logic [2:0]  drq_out_q,
    input wire logic [2:0]  drq_oe_q,
    input wire logic [7:0]  turnaround_timeout_q,
    input wire logic [19:0] turnaround_cycles_q,
    input wire logic [7:0]  ssel_first_q
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // Read answer and idle bus
    a_rd_oe_pulse: assert property (cfg_state && dat_rd |=> cfg_rdata_oe_q)
        else $error("read strobe missing after config read");
    a_oe_only_cfg: assert property (!(cfg_state && dat_rd) |=> !cfg_rdata_oe_q)
        else $error("read strobe without config read");
    a_rdata_idle_zero: assert property (!cfg_rdata_oe_q |-> cfg_rdata_q == 8'h00)
        else $error("read data driven while idle");
    // Only one channel driven, never an undriven one
    a_drq_onehot: assert property ($onehot0(drq_oe_q))
        else $error("more than one request line driven");
    a_drq_undriven: assert property ((drq_out_q & ~drq_oe_q) == 3'h0)
        else $error("request active on undriven line");
    // Cycle count registers together with the byte, 2500 clocks per step
    a_cycles_scale: assert property
        (turnaround_cycles_q == {12'h000, turnaround_timeout_q} * 20'h009c4)
        else $error("turnaround cycles not byte times step");
    a_eng_valid: assert property (eng_rd |=> eng_rdata_valid_q)
        else $error("engine read not answered");
    a_ssel_mirror: assert property
        (eng_rd && eng_block == 3'h3 && eng_offset == 3'h5 |=> eng_rdata_q == ssel_first_q)
        else $error("software select copies differ");
    a_tmo_mirror: assert property
        (eng_rd && eng_block == 3'h5 && eng_offset == 3'h1 |=> eng_rdata_q == turnaround_timeout_q)
        else $error("time-out copies differ");

    c_cfg_read: cover property (cfg_state && dat_rd);
    c_drq_on: cover property (drq_oe_q != 3'h0 && drq_out_q != 3'h0);
    c_tmo_read: cover property (eng_rd && eng_block == 3'h5);
endmodule : fir_cfg_regs_chk

bind fir_cfg_regs fir_cfg_regs_chk fir_cfg_regs_chk_inst (
    .clk(clk), .rst(rst), .cfg_state(cfg_state), .dat_rd(dat_rd), .eng_rd(eng_rd),
    .eng_block(eng_block), .eng_offset(eng_offset), .cfg_rdata_q(cfg_rdata_q),
    .cfg_rdata_oe_q(cfg_rdata_oe_q), .eng_rdata_q(eng_rdata_q),
    .eng_rdata_valid_q(eng_rdata_valid_q), .drq_out_q(drq_out_q), .drq_oe_q(drq_oe_q),
    .turnaround_timeout_q(turnaround_timeout_q), .turnaround_cycles_q(turnaround_cycles_q),
    .ssel_first_q(ssel_first_q)
);

`default_nettype wire

// [verification/tb_fir_cfg_regs.sv]
`default_nettype none

module tb_fir_cfg_regs;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst, cfg_state, idx_wr, dat_wr, dat_rd, chip_select_low, oe, eng_sel;
    logic        eng_wr, eng_rd, eng_soft_rst, eng_dma_req, cfg_rdata_oe_q, eng_rdata_valid_q;
    logic [7:0]  cfg_wdata, eng_wdata, rd, cfg_rdata_q, idx_q, eng_rdata_q, tmo_q, ss1_q, ss2_q;
    logic [2:0]  eng_block, eng_offset, ofs_q, drq_out_q, drq_oe_q;
    logic [15:0] host_addr;
    logic [19:0] cyc_q;
    int          err_total = 0;
    int          cmp_count = 0;

    fir_cfg_regs fir_cfg_regs_inst (
        .clk(clk), .rst(rst), .cfg_state(cfg_state), .idx_wr(idx_wr), .dat_wr(dat_wr),
        .dat_rd(dat_rd), .cfg_wdata(cfg_wdata), .cfg_rdata_q(cfg_rdata_q),
        .cfg_rdata_oe_q(cfg_rdata_oe_q), .config_index_register_q(idx_q),
        .host_addr(host_addr), .chip_select_low(chip_select_low), .eng_select_q(eng_sel),
        .eng_reg_offset_q(ofs_q), .eng_wr(eng_wr), .eng_rd(eng_rd), .eng_block(eng_block),
        .eng_offset(eng_offset), .eng_wdata(eng_wdata), .eng_soft_rst(eng_soft_rst),
        .eng_rdata_q(eng_rdata_q), .eng_rdata_valid_q(eng_rdata_valid_q),
        .eng_dma_req(eng_dma_req), .drq_out_q(drq_out_q), .drq_oe_q(drq_oe_q),
        .turnaround_timeout_q(tmo_q), .turnaround_cycles_q(cyc_q),
        .ssel_first_q(ss1_q), .ssel_second_q(ss2_q)
    );

    // 25 MHz clock
    always #20 clk = ~clk;

    // Inputs move 2 ns after the edge so the design samples settled values
    task automatic tick();
        @(posedge clk);
        #2;
    endtask : tick

    task automatic check(input logic [19:0] seen, input logic [19:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Index load then one data write or read; read data lands one clock later
    task automatic cfg_acc(input logic [7:0] idx, input logic wr, input logic [7:0] data);
        idx_wr = 1'b1;
        cfg_wdata = idx;
        tick();
        idx_wr = 1'b0;
        dat_wr = wr;
        dat_rd = !wr;
        cfg_wdata = data;
        tick();
        dat_wr = 1'b0;
        dat_rd = 1'b0;
        rd = cfg_rdata_q;
        oe = cfg_rdata_oe_q;
    endtask : cfg_acc

    task automatic eng_acc(input logic [2:0] blk, ofs, input logic wr, input logic [7:0] data);
        eng_block = blk;
        eng_offset = ofs;
        eng_wr = wr;
        eng_rd = !wr;
        eng_wdata = data;
        tick();
        eng_wr = 1'b0;
        eng_rd = 1'b0;
        rd = eng_rdata_q;
        oe = eng_rdata_valid_q;
    endtask : eng_acc

    task automatic t_reset();
        logic [7:0] exp [5] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h00};
        check(idx_q, 8'h00);
        check(cyc_q, 20'h01d4c);
        for (int i = 0; i < 5; i++) begin
            cfg_acc(8'h2b + i[7:0], 1'b0, 8'h00);
            check(rd, exp[i]);
            check(oe, 1'b1);
        end
        check(idx_q, 8'h2f);
    endtask : t_reset

    // Every channel code plus one unused code, reserved bits written high
    task automatic t_dma();
        logic [2:0] exp;
        for (int c = 0; c < 5; c++) begin
            exp = (c >= 1 && c <= 3) ? 3'h1 << (c - 1) : 3'h0;
            cfg_acc(8'h2c, 1'b1, 8'hf0 | c[7:0]);
            cfg_acc(8'h2c, 1'b0, 8'h00);
            check(rd, {4'h0, c[3:0]});
            eng_dma_req = 1'b1;
            repeat (2) tick();
            check(drq_oe_q, exp);
            check(drq_out_q, exp);
            eng_dma_req = 1'b0;
            repeat (2) tick();
            check(drq_out_q, 3'h0);
        end
    endtask : t_dma

    // Both time-out copies follow either writer, survive soft reset, reload on reset
    task automatic t_tmo();
        cfg_acc(8'h2d, 1'b1, 8'h55);
        repeat (3) tick();
        check(tmo_q, 8'h55);
        check(cyc_q, 20'h33e14);
        eng_acc(3'h5, 3'h1, 1'b0, 8'h00);
        check(rd, 8'h55);
        eng_acc(3'h5, 3'h1, 1'b1, 8'hff);
        cfg_acc(8'h2d, 1'b0, 8'h00);
        check(rd, 8'hff);
        repeat (2) tick();
        check(cyc_q, 20'h9ba3c);
        eng_soft_rst = 1'b1;
        tick();
        eng_soft_rst = 1'b0;
        eng_acc(3'h5, 3'h1, 1'b0, 8'h00);
        check(rd, 8'hff);
        check(tmo_q, 8'hff);
        rst = 1'b1;
        tick();
        rst = 1'b0;
        eng_acc(3'h5, 3'h1, 1'b0, 8'h00);
        check(rd, 8'h03);
    endtask : t_tmo

    task automatic t_ssel();
        for (int i = 0; i < 2; i++) begin
            cfg_acc(8'h2e + i[7:0], 1'b1, 8'ha5 + i[7:0]);
            eng_acc(3'h3, 3'h5 + i[2:0], 1'b0, 8'h00);
            check(rd, 8'ha5 + i[7:0]);
            check(oe, 1'b1);
            eng_acc(3'h3, 3'h5 + i[2:0], 1'b1, 8'h3c + i[7:0]);
            cfg_acc(8'h2e + i[7:0], 1'b0, 8'h00);
            check(rd, 8'h3c + i[7:0]);
        end
        tick();
        check(ss1_q, 8'h3c);
        check(ss2_q, 8'h3d);
    endtask : t_ssel

    // Outside configuration state nothing is written and nothing answers
    task automatic t_outside();
        cfg_state = 1'b0;
        cfg_acc(8'h2e, 1'b1, 8'h77);
        cfg_acc(8'h2e, 1'b0, 8'h00);
        check(oe, 1'b0);
        check(rd, 8'h00);
        check(ss2_q, 8'h3d);
        cfg_state = 1'b1;
        cfg_acc(8'h2e, 1'b0, 8'h00);
        check(rd, 8'h3c);
    endtask : t_outside

    // Four clocks cover the select synchroniser and the registered match
    task automatic dec(input logic [7:0] base, input logic [15:0] addr, input logic cs,
                       input logic exp);
        cfg_acc(8'h2b, 1'b1, base);
        host_addr = addr;
        chip_select_low = cs;
        repeat (4) tick();
        check(eng_sel, exp);
        check(ofs_q, addr[2:0]);
    endtask : dec

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        cfg_state = 1'b0;
        chip_select_low = 1'b1;
        {idx_wr, dat_wr, dat_rd, eng_wr, eng_rd, eng_soft_rst, eng_dma_req} = '0;
        {cfg_wdata, eng_wdata, eng_block, eng_offset, host_addr} = '0;
        repeat (2) @(posedge clk);
        #2;
        rst = 1'b0;
        cfg_state = 1'b1;
        t_reset();
        t_dma();
        t_tmo();
        t_ssel();
        t_outside();
        dec(8'h20, 16'hf905, 1'b0, 1'b1);
        dec(8'h20, 16'h0108, 1'b0, 1'b0);
        dec(8'h20, 16'h0107, 1'b1, 1'b0);
        dec(8'h1f, 16'h00f8, 1'b0, 1'b0);
        dec(8'hff, 16'h07fe, 1'b0, 1'b1);
        final_report();
    end

    // Whole run is about 120 clocks; 100 us means a hang
    initial begin
        #100000;
        err_total++;
        final_report();
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : final_report
endmodule : tb_fir_cfg_regs

`default_nettype wire
